// *** live_cfg_pkg.sv ***
// Constants, encodings and TAP states for the live verify/reconfiguration port.
// Assumes one system clock at 50 MHz and a JTAG clock from the external programmer.
package live_cfg_pkg;
   localparam int          CLK_PERIOD_NS    = 20;
   localparam int          RELOAD_TIME_US   = 800;
   localparam int          RELOAD_CYCLES    = (RELOAD_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int          SETTLE_TIME_US   = 20;
   localparam int          DISCHARGE_TIME_US = 20;
   localparam int          TLR_ENTRY_EDGES  = 5;
   localparam int          IR_LEN           = 8;
   localparam int          ROW_BITS         = 274;
   localparam int          ADDR_BITS        = 7;
   localparam int          DR_LEN           = ROW_BITS + ADDR_BITS;
   // Instruction codes, bit 7 down to bit 0 (bit 0 is shifted first)
   localparam logic [7:0]  live_enable_code = 8'hE4;
   localparam logic [7:0]  ROW_READBACK_CODE = 8'hEE;
   localparam logic [7:0]  LEAVE_CONFIG_CODE = 8'hC0;
   localparam logic [7:0]  DISCHARGE_CODE   = 8'hF0;
   localparam logic [7:0]  RELOAD_CODE      = 8'hF0;
   localparam logic [7:0]  BYPASS_CODE      = 8'hFF;
   // Register map (byte addresses)
   localparam logic [3:0]  CTRL_OFFSET      = 4'h0;
   localparam logic [3:0]  STATUS_OFFSET    = 4'h4;
   localparam logic [3:0]  RELOADS_OFFSET   = 4'h8;
   localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
   // Field positions
   localparam int          CTRL_SECURE_BIT  = 0;
   localparam int          CTRL_DONE_BIT    = 1;
   localparam int          ST_LIVE_BIT      = 0;
   localparam int          ST_USER_BIT      = 1;
   localparam int          ST_DISCH_BIT     = 2;
   localparam int          ST_RELOAD_BIT    = 3;
   localparam int          ST_ROW_LSB       = 8;
   localparam logic [1:0]  RESP_OKAY        = 2'b00;
   localparam logic [1:0]  RESP_SLVERR      = 2'b10;

   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
   } tap_state_t;
endpackage

// *** live_cfg_port.sv ***
// Live verify and reconfiguration port: TAP logic on tck, control on aclk.
// Assumes an external programmer on tck/tms/tdi/tdo, NV rows readable in one
// aclk cycle on nv_rd_addr/nv_rd_data, and an AXI4-Lite master for software.
// Summary of operation
// - Status shifts out while bypass code shifts in
// - Live-enable at Update-IR sets configuration enable flag
// - Instructions are eight bits, MSB on exit edge
// - Row-readback instruction code recognised
// - First data scan loads row address only
// - Row data out MSB first, then next address
// - Readback never disturbs running user logic
// - Leave-config executes in Run-Test/Idle after update
// - Falling tck in Test-Logic-Reset restores user mode
// - Discharge instruction drives high-voltage discharge in idle
// - Reload armed by empty data scan after discharge
// - Reload runs for the initialisation time
// - User outputs high impedance during reload
`timescale 1ns/1ps
module live_cfg_port
   import live_cfg_pkg::*;
#(
   parameter int RELOAD_COUNT = RELOAD_CYCLES
) (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic                  ce,
   input  wire logic                  tck,
   input  wire logic                  tms,
   input  wire logic                  tdi,
   output logic                       tdo,
   output logic                       tdo_oe,
   output logic [ADDR_BITS-1:0]       nv_rd_addr,
   input  wire logic [ROW_BITS-1:0]   nv_rd_data,
   output logic                       user_outputs_hiz,
   output logic                       hv_discharge,
   output logic                       reload_done,
   input  wire logic [3:0]            s_axil_awaddr,
   input  wire logic                  s_axil_awvalid,
   output logic                       s_axil_awready,
   input  wire logic [31:0]           s_axil_wdata,
   input  wire logic [3:0]            s_axil_wstrb,
   input  wire logic                  s_axil_wvalid,
   output logic                       s_axil_wready,
   output logic [1:0]                 s_axil_bresp,
   output logic                       s_axil_bvalid,
   input  wire logic                  s_axil_bready,
   input  wire logic [3:0]            s_axil_araddr,
   input  wire logic                  s_axil_arvalid,
   output logic                       s_axil_arready,
   output logic [31:0]                s_axil_rdata,
   output logic [1:0]                 s_axil_rresp,
   output logic                       s_axil_rvalid,
   input  wire logic                  s_axil_rready
);

   function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
      unique case (s)
         TLR:    tap_next = m ? TLR    : RTI;
         RTI:    tap_next = m ? SEL_DR : RTI;
         SEL_DR: tap_next = m ? SEL_IR : CAP_DR;
         CAP_DR: tap_next = m ? EX1_DR : SH_DR;
         SH_DR:  tap_next = m ? EX1_DR : SH_DR;
         EX1_DR: tap_next = m ? UPD_DR : PAU_DR;
         PAU_DR: tap_next = m ? EX2_DR : PAU_DR;
         EX2_DR: tap_next = m ? UPD_DR : SH_DR;
         UPD_DR: tap_next = m ? SEL_DR : RTI;
         SEL_IR: tap_next = m ? TLR    : CAP_IR;
         CAP_IR: tap_next = m ? EX1_IR : SH_IR;
         SH_IR:  tap_next = m ? EX1_IR : SH_IR;
         EX1_IR: tap_next = m ? UPD_IR : PAU_IR;
         PAU_IR: tap_next = m ? EX2_IR : PAU_IR;
         EX2_IR: tap_next = m ? UPD_IR : SH_IR;
         UPD_IR: tap_next = m ? SEL_DR : RTI;
      endcase
   endfunction

   // ---------------- tck domain ----------------
   logic                 tck_rst_meta, tck_rst_n;
   logic                 secure_meta, secure_t, done_meta, done_t;
   logic                 ack_meta, ack_sync, ack_seen;
   tap_state_t           state;
   logic [IR_LEN-1:0]    ir, ir_sr;
   logic [DR_LEN-1:0]    dr_sr;
   logic                 bypass_bit;
   logic                 live_enable;
   logic                 discharged;
   logic                 leave_pending;
   logic                 shifted_dr;
   logic [ADDR_BITS-1:0] row_addr_t;
   logic                 rd_req_tgl;
   logic                 reload_tgl;
   logic                 discharge_t;
   logic                 user_mode;
   logic                 in_readback;
   logic                 reload_sel;
   logic [ROW_BITS-1:0]  row_data_x;
   logic                 rd_ack_tgl;
   logic [31:0]          ctrl;

   // Reset and status levels enter the tck domain through two flops
   always_ff @(posedge tck) begin
      tck_rst_meta <= aresetn;
      tck_rst_n    <= tck_rst_meta;
      secure_meta  <= ctrl[CTRL_SECURE_BIT];
      secure_t     <= secure_meta;
      done_meta    <= ctrl[CTRL_DONE_BIT];
      done_t       <= done_meta;
      ack_meta     <= rd_ack_tgl;
      ack_sync     <= ack_meta;
   end

   always_ff @(posedge tck) begin
      if (!tck_rst_n) begin
         state <= TLR;
      end else begin
         state <= tap_next(state, tms);
      end
   end

   assign in_readback = live_enable && (ir == ROW_READBACK_CODE);

   // Instruction path: status captured, LSB first, bit 7 on the exit edge
   always_ff @(posedge tck) begin
      if (!tck_rst_n || state == TLR) begin
         ir_sr <= BYPASS_CODE;
         ir    <= BYPASS_CODE;
      end else begin
         unique case (state)
            CAP_IR:  ir_sr <= {4'h0, done_t, secure_t, 2'b01};
            SH_IR:   ir_sr <= {tdi, ir_sr[IR_LEN-1:1]};
            UPD_IR:  ir    <= ir_sr;
            default: ir_sr <= ir_sr;
         endcase
      end
   end

   // Configuration enable, discharge/reload sequencing and leave-config
   always_ff @(posedge tck) begin
      if (!tck_rst_n || state == TLR) begin
         live_enable   <= 1'b0;
         discharged    <= 1'b0;
         reload_sel    <= 1'b0;
         leave_pending <= 1'b0;
         reload_tgl    <= reload_tgl & tck_rst_n;
         discharge_t   <= 1'b0;
      end else begin
         if (state == UPD_IR) begin
            if (ir_sr == live_enable_code)
               live_enable <= 1'b1;
            leave_pending <= (ir_sr == LEAVE_CONFIG_CODE);
            if (live_enable && ir_sr == DISCHARGE_CODE && ir != DISCHARGE_CODE)
               discharged <= 1'b0;
            // Second discharge-coded load after a discharge selects the reload
            reload_sel <= (ir_sr == RELOAD_CODE) && (ir == DISCHARGE_CODE) && discharged;
         end
         if (state == RTI && leave_pending) begin
            live_enable   <= 1'b0;
            leave_pending <= 1'b0;
         end
         // Discharge starts one tck into Run-Test/Idle and lasts until Run-Test/Idle is left
         discharge_t <= (state == RTI) && !tms && live_enable && !reload_sel
                        && (ir == DISCHARGE_CODE);
         if (state == RTI && discharge_t)
            discharged <= 1'b1;
         // Second discharge-coded instruction is the reload, fired by an empty scan
         if (state == UPD_DR && live_enable && reload_sel
             && ir == RELOAD_CODE && !shifted_dr)
            reload_tgl <= ~reload_tgl;
      end
   end

   // Data path: row data out MSB first, address in behind it
   always_ff @(posedge tck) begin
      if (!tck_rst_n) begin
         dr_sr      <= '0;
         bypass_bit <= 1'b0;
         shifted_dr <= 1'b0;
         row_addr_t <= '0;
         rd_req_tgl <= 1'b0;
         ack_seen   <= 1'b0;
      end else begin
         unique case (state)
            CAP_DR: begin
               dr_sr      <= {row_data_x, {ADDR_BITS{1'b1}}};
               bypass_bit <= 1'b0;
               shifted_dr <= 1'b0;
            end
            SH_DR: begin
               dr_sr      <= {dr_sr[DR_LEN-2:0], tdi};
               bypass_bit <= tdi;
               shifted_dr <= 1'b1;
            end
            UPD_DR: begin
               if (in_readback) begin
                  row_addr_t <= dr_sr[ADDR_BITS-1:0];
                  rd_req_tgl <= ~rd_req_tgl;
               end
            end
            default: dr_sr <= dr_sr;
         endcase
         ack_seen <= ack_sync;
      end
   end

   // TDO and user mode change on the falling edge
   always_ff @(negedge tck) begin
      if (!tck_rst_n) begin
         tdo       <= 1'b0;
         tdo_oe    <= 1'b0;
         user_mode <= 1'b1;
      end else begin
         tdo_oe <= (state == SH_IR) || (state == SH_DR);
         if (state == SH_IR)
            tdo <= ir_sr[0];
         else if (state == SH_DR)
            tdo <= in_readback ? dr_sr[DR_LEN-1] : bypass_bit;
         if (state == TLR)
            user_mode <= 1'b1;
         else if (live_enable)
            user_mode <= 1'b0;
      end
   end

   // ---------------- aclk domain ----------------
   logic [2:0]           rd_req_s;
   logic [2:0]           reload_s;
   logic [1:0]           live_s, user_s, disch_s;
   logic [31:0]          reload_total;
   logic [31:0]          reload_cnt;
   logic                 reloading;
   logic                 rd_phase;
   logic                 aw_held, w_held;
   logic [3:0]           aw_addr;
   logic [31:0]          w_data;
   logic [3:0]           w_strb;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_req_s <= '0;
         reload_s <= '0;
         live_s   <= '0;
         user_s   <= 2'b11;
         disch_s  <= '0;
      end else if (ce) begin
         rd_req_s <= {rd_req_s[1:0], rd_req_tgl};
         reload_s <= {reload_s[1:0], reload_tgl};
         live_s   <= {live_s[0], live_enable};
         user_s   <= {user_s[0], user_mode};
         disch_s  <= {disch_s[0], discharge_t};
      end
   end

   // Row fetch: address out, data held stable, then ack toggled back
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nv_rd_addr <= '0;
         row_data_x <= {ROW_BITS{1'b1}};
         rd_ack_tgl <= 1'b0;
         rd_phase   <= 1'b0;
      end else if (ce) begin
         if (rd_req_s[2] != rd_req_s[1]) begin
            nv_rd_addr <= row_addr_t;
            rd_phase   <= 1'b1;
         end else if (rd_phase) begin
            row_data_x <= nv_rd_data;
            rd_ack_tgl <= ~rd_ack_tgl;
            rd_phase   <= 1'b0;
         end
      end
   end

   // Reload timer; readback never touches these outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reloading    <= 1'b0;
         reload_cnt   <= '0;
         reload_total <= '0;
         reload_done  <= 1'b0;
      end else if (ce) begin
         reload_done <= 1'b0;
         if (reload_s[2] != reload_s[1]) begin
            reloading  <= 1'b1;
            reload_cnt <= 32'(RELOAD_COUNT);
         end else if (reloading) begin
            if (reload_cnt <= 32'd1) begin
               reloading    <= 1'b0;
               reload_done  <= 1'b1;
               reload_total <= reload_total + 32'd1;
            end else begin
               reload_cnt <= reload_cnt - 32'd1;
            end
         end
      end
   end

   assign user_outputs_hiz = reloading;
   assign hv_discharge     = disch_s[1];

   // AXI4-Lite write
   assign s_axil_awready = !aw_held && !s_axil_bvalid;
   assign s_axil_wready  = !w_held && !s_axil_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= '0;
         w_data        <= '0;
         w_strb        <= '0;
         s_axil_bvalid <= 1'b0;
         s_axil_bresp  <= RESP_OKAY;
         ctrl          <= CTRL_RESET;
      end else if (ce) begin
         if (s_axil_awvalid && s_axil_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axil_awaddr;
         end
         if (s_axil_wvalid && s_axil_wready) begin
            w_held <= 1'b1;
            w_data <= s_axil_wdata;
            w_strb <= s_axil_wstrb;
         end
         if (aw_held && w_held) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            s_axil_bvalid <= 1'b1;
            if (aw_addr == CTRL_OFFSET) begin
               s_axil_bresp <= RESP_OKAY;
               for (int b = 0; b < 4; b++)
                  if (w_strb[b])
                     ctrl[b*8 +: 8] <= w_data[b*8 +: 8];
            end else begin
               s_axil_bresp <= (aw_addr == STATUS_OFFSET || aw_addr == RELOADS_OFFSET)
                               ? RESP_OKAY : RESP_SLVERR;
            end
         end else if (s_axil_bvalid && s_axil_bready) begin
            s_axil_bvalid <= 1'b0;
         end
      end
   end

   // AXI4-Lite read
   assign s_axil_arready = !s_axil_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axil_rvalid <= 1'b0;
         s_axil_rdata  <= '0;
         s_axil_rresp  <= RESP_OKAY;
      end else if (ce) begin
         if (s_axil_arvalid && s_axil_arready) begin
            s_axil_rvalid <= 1'b1;
            s_axil_rresp  <= RESP_OKAY;
            s_axil_rdata  <= '0;
            unique case (s_axil_araddr)
               CTRL_OFFSET:    s_axil_rdata <= ctrl & 32'h0000_0003;
               STATUS_OFFSET: begin
                  s_axil_rdata[ST_LIVE_BIT]   <= live_s[1];
                  s_axil_rdata[ST_USER_BIT]   <= user_s[1];
                  s_axil_rdata[ST_DISCH_BIT]  <= disch_s[1];
                  s_axil_rdata[ST_RELOAD_BIT] <= reloading;
                  s_axil_rdata[ST_ROW_LSB +: ADDR_BITS] <= nv_rd_addr;
               end
               RELOADS_OFFSET: s_axil_rdata <= reload_total;
               default:        s_axil_rresp <= RESP_SLVERR;
            endcase
         end else if (s_axil_rvalid && s_axil_rready) begin
            s_axil_rvalid <= 1'b0;
         end
      end
   end

endmodule // live_cfg_port

// *** live_cfg_port_properties.sv ***
// Checker of the live configuration port: read answers, reload timing, shift enable.
// Assumes ce is high during register reads and reloads, so edges count timer cycles.
`timescale 1ns/1ps
module live_cfg_checker #(
   parameter int RELOAD_COUNT = 20
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdo_oe,
   input wire logic user_outputs_hiz,
   input wire logic hv_discharge,
   input wire logic reload_done,
   input wire logic s_axil_arvalid,
   input wire logic s_axil_arready,
   input wire logic s_axil_rvalid,
   input wire logic s_axil_rready
);
   int hcnt;

   // Length of the current high-impedance run
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hcnt <= 0;
      end else begin
         hcnt <= user_outputs_hiz ? hcnt + 1 : 0;
      end
   end

   property p_rd_answer;
      @(posedge aclk) disable iff (!aresetn) s_axil_arvalid && s_axil_arready |=> s_axil_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
   property p_rd_hold;
      @(posedge aclk) disable iff (!aresetn) s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid;
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped");
   property p_done_pulse;
      @(posedge aclk) disable iff (!aresetn) reload_done |=> !reload_done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done pulse too long");
   property p_hiz_len;
      @(posedge aclk) disable iff (!aresetn) $fell(user_outputs_hiz) |-> hcnt == RELOAD_COUNT;
   endproperty
   a_hiz_len: assert property (p_hiz_len) else $error("reload length wrong");
   property p_done_hiz;
      @(posedge aclk) disable iff (!aresetn) reload_done |-> $past(user_outputs_hiz);
   endproperty
   a_done_hiz: assert property (p_done_hiz) else $error("done without reload");
   property p_disch;
      @(posedge aclk) disable iff (!aresetn) hv_discharge |-> !user_outputs_hiz;
   endproperty
   a_disch: assert property (p_disch) else $error("discharge during reload");
   property p_oe_shift;
      @(posedge tck) disable iff (!aresetn) tdo_oe |-> !$past(tms);
   endproperty
   a_oe_shift: assert property (p_oe_shift) else $error("tdo driven outside shift");
   property p_tlr;
      @(posedge tck) disable iff (!aresetn) tms [*5] |=> !tdo_oe;
   endproperty
   a_tlr: assert property (p_tlr) else $error("tdo driven after reset walk");
endmodule // live_cfg_checker

bind live_cfg_port live_cfg_checker #(.RELOAD_COUNT(RELOAD_COUNT)) chk_u (
   .aclk, .aresetn, .tck, .tms, .tdo_oe, .user_outputs_hiz, .hv_discharge, .reload_done,
   .s_axil_arvalid, .s_axil_arready, .s_axil_rvalid, .s_axil_rready
);

// *** jtag_prog_model.sv ***
// Behavioural programmer: drives tck, tms, tdi and samples tdo at each rising tck.
// Assumes tdo moves on falling tck; tck stands low between steps, tdi rests at 1.
`timescale 1ns/1ps
module jtag_prog_model (
   output logic     tck,
   output logic     tms,
   output logic     tdi,
   input wire logic tdo
);
   logic [280:0] cap;

   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #15 tck = 1'b1;
      q = tdo;
      #15 tck = 1'b0;
      tdi = 1'b1;
   endtask

   // Walk of tms bits, first bit in bit 0
   task automatic go(input logic [15:0] ms, input int n);
      logic q;
      for (int i = 0; i < n; i++) step(ms[i], 1'b1, q);
   endtask

   task automatic reset_idle();
      go(16'h001F, 6);
   endtask

   task automatic idle(input int n);
      logic q;
      repeat (n) step(1'b0, 1'b1, q);
   endtask

   // From idle through one scan, last bit on the exit edge, back to idle
   task automatic scan(input logic ir, input int n, input logic [280:0] din);
      logic q;
      if (ir) step(1'b1, 1'b1, q);
      go(16'h0001, 3);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         cap[i] = q;
      end
      go(16'h0001, 2);
   endtask

   // Ones while data leaves, then address bit 6 first
   function automatic logic [280:0] mk(input int n, input logic [6:0] a);
      mk = '1;
      for (int i = n - 7; i < n; i++) mk[i] = a[n - 1 - i];
   endfunction

   function automatic logic [273:0] row();
      for (int i = 0; i < 274; i++) row[273 - i] = cap[i];
   endfunction
endmodule // jtag_prog_model

// *** test_live_verify_reconfig_jtag.sv ***
// Bench of the live configuration port: register master, programmer model, row memory.
// Assumes the reload count cut to RCNT cycles; programmer waits are fixed step counts sized for it.
`timescale 1ns/1ps
module test_live_verify_reconfig_jtag
   import live_cfg_pkg::*;
;
   localparam int RCNT = 20;
   logic          aclk, aresetn, ce, tck, tms, tdi, tdo, tdo_oe;
   logic          user_outputs_hiz, hv_discharge, reload_done;
   logic [6:0]    nv_rd_addr, a0, a1, a2;
   logic [273:0]  nv_rd_data;
   logic [273:0]  rows [128];
   logic [3:0]    s_axil_awaddr, s_axil_araddr, s_axil_wstrb, sb;
   logic [31:0]   s_axil_wdata, s_axil_rdata, q;
   logic [1:0]    s_axil_bresp, s_axil_rresp, r, ctrl;
   logic          s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
   logic          s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready;
   logic          s_axil_rvalid, s_axil_rready;
   int            fail_count, n_checks, reloads;

   live_cfg_port #(.RELOAD_COUNT(RCNT)) dut_u (.*);
   jtag_prog_model prog_u (.tck, .tms, .tdi, .tdo);

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // Row memory answers combinationally, in the same cycle as the address changes
   assign nv_rd_data = rows[nv_rd_addr];

   task automatic close_out();
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic cmp_w(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic cmp_r(input logic [273:0] g, input logic [273:0] e);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic axi(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic [1:0] rs);
      int n;
      logic ha, hw, hd;
      @(posedge aclk);
      s_axil_awaddr <= a;
      s_axil_araddr <= a;
      s_axil_wdata <= d;
      s_axil_awvalid <= w;
      s_axil_wvalid <= w;
      s_axil_bready <= w;
      s_axil_arvalid <= !w;
      s_axil_rready <= !w;
      for (n = 0; n < 200; n++) begin
         @(negedge aclk);
         ha = (s_axil_awvalid && s_axil_awready) || (s_axil_arvalid && s_axil_arready);
         hw = s_axil_wvalid && s_axil_wready;
         hd = w ? s_axil_bvalid : s_axil_rvalid;
         rd = s_axil_rdata;
         rs = w ? s_axil_bresp : s_axil_rresp;
         @(posedge aclk);
         if (ha) s_axil_awvalid <= 1'b0;
         if (ha) s_axil_arvalid <= 1'b0;
         if (hw) s_axil_wvalid <= 1'b0;
         if (hd) break;
      end
      s_axil_bready <= 1'b0;
      s_axil_rready <= 1'b0;
      if (n >= 200) fail_count++;
      if (n >= 200) close_out();
   endtask

   // Leave, bypass, walk to reset, then the old or new pattern runs on
   task automatic finish_live();
      prog_u.scan(1, 8, 281'(LEAVE_CONFIG_CODE));
      prog_u.scan(1, 8, 281'(BYPASS_CODE));
      prog_u.go(16'h0007, 3);
      repeat (4) @(posedge aclk);
      axi(0, STATUS_OFFSET, '0, q, r);
      cmp_w(q & 32'hF, 32'h2);
      axi(0, RELOADS_OFFSET, '0, q, r);
      cmp_w(q, 32'(reloads));
   endtask

   initial begin
      {aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready} = '0;
      {s_axil_arvalid, s_axil_rready, s_axil_awaddr, s_axil_araddr, s_axil_wdata} = '0;
      s_axil_wstrb = 4'hF;
      ce = 1'b1;
      fail_count = 0;
      n_checks = 0;
      reloads = 0;
      q = $urandom(32'h0FF48B8C);
      foreach (rows[i])
         for (int k = 0; k < 274; k++) rows[i][k] = 1'($urandom);
      fork
         prog_u.go(16'hFFFF, 10);
         repeat (20) @(posedge aclk);
      join
      aresetn <= 1'b1;
      axi(0, CTRL_OFFSET, '0, q, r);
      cmp_w(q, CTRL_RESET);
      axi(0, STATUS_OFFSET, '0, q, r);
      cmp_w(q, 32'h0000_0002);
      axi(0, 4'hC, '0, q, r);
      cmp_w(32'(r), 32'(RESP_SLVERR));
      ctrl = 2'($urandom);
      sb = 4'($urandom);
      s_axil_wstrb <= sb;
      axi(1, CTRL_OFFSET, 32'h3, q, r);
      s_axil_wstrb <= 4'hF;
      axi(0, CTRL_OFFSET, '0, q, r);
      cmp_w(q, sb[0] ? 32'h3 : 32'h0);
      axi(1, CTRL_OFFSET, 32'(ctrl), q, r);
      cmp_w(32'(r), 32'(RESP_OKAY));
      axi(0, CTRL_OFFSET, '0, q, r);
      cmp_w(q, 32'(ctrl));
      prog_u.reset_idle();
      prog_u.scan(1, 8, 281'(BYPASS_CODE));
      cmp_w(32'(prog_u.cap[7:0]), {28'h0, ctrl, 2'b01});
      prog_u.scan(1, 8, 281'(live_enable_code));
      repeat (4) @(posedge aclk);
      axi(0, STATUS_OFFSET, '0, q, r);
      cmp_w(q & 32'h3, 32'h1);
      prog_u.scan(1, 8, 281'(ROW_READBACK_CODE));
      {a0, a1, a2} = 21'($urandom);
      prog_u.scan(0, 7, prog_u.mk(7, a0));
      // Clock enable wanders while the first row is fetched
      repeat (4 + $urandom % 8) @(posedge aclk) ce <= 1'($urandom);
      @(posedge aclk) ce <= 1'b1;
      prog_u.idle(667);
      prog_u.scan(0, 281, prog_u.mk(281, a1));
      cmp_r(prog_u.row(), rows[a0]);
      prog_u.idle(667);
      prog_u.scan(0, 281, prog_u.mk(281, a2));
      cmp_r(prog_u.row(), rows[a1]);
      prog_u.idle(667);
      axi(0, STATUS_OFFSET, '0, q, r);
      cmp_w(q & 32'h7F00, {17'h0, a2, 8'h0});
      finish_live();
      prog_u.reset_idle();
      prog_u.scan(1, 8, 281'(RELOAD_CODE));
      prog_u.go(16'h000D, 5);
      prog_u.idle(40);
      axi(0, RELOADS_OFFSET, '0, q, r);
      cmp_w(q, 32'(reloads));
      prog_u.scan(1, 8, 281'(live_enable_code));
      prog_u.scan(1, 8, 281'(DISCHARGE_CODE));
      prog_u.idle(667);
      cmp_w(32'(hv_discharge), 32'h1);
      prog_u.scan(1, 8, 281'(RELOAD_CODE));
      prog_u.go(16'h000D, 5);
      prog_u.idle(5);
      cmp_w(32'(user_outputs_hiz), 32'h1);
      prog_u.idle(40);
      cmp_w(32'(user_outputs_hiz), 32'h0);
      reloads++;
      finish_live();
      close_out();
   end
endmodule // test_live_verify_reconfig_jtag
